// ### srpd_ctrl.sv
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module srpd_ctrl #(
  parameter int NTX = 3,
  parameter int NRX = 3,
  parameter int IDLE_TICKS = srpd_pkg::IDLE_SLEEP_TICKS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Force pins
  input wire logic force_active_in,
  input wire logic force_sleep_n_in,
  // Transmitter side
  input wire logic [NTX-1:0] tx_data_in,
  output logic [NTX-1:0] tx_line_out,
  output logic [NTX-1:0] tx_line_oe_n,
  // Receiver side
  input wire logic [NRX-1:0] rx_level_in,
  input wire logic [NRX-1:0] rx_valid_in,
  output logic [NRX-1:0] rx_data_out,
  // Power and status
  output logic pump_en,
  output logic tx_ready,
  output logic line_invalid_n
);
  // Synchroniser layout, low bits first: transmitter data, receiver levels,
  // receiver validity, force-active, force-sleep.
  localparam int SW = NTX + 2 * NRX + 2;
  localparam int LW = NTX + NRX;
  localparam int CW = srpd_pkg::CNT_W;
  localparam int IW = srpd_pkg::IDLE_W;
  localparam int DW = $clog2(srpd_pkg::TICK_CYC);
  localparam int TICK_LAST = srpd_pkg::TICK_CYC - 1;
  localparam int IDLE_LAST = IDLE_TICKS - 1; // [RULE20]
  localparam int SETTLE_LAST = srpd_pkg::PUMP_SETTLE_CYC - 1;
  localparam int INV_LAST = srpd_pkg::INVALID_CYC - 1;
  localparam int VAL_LAST = srpd_pkg::VALID_CYC - 1;
  localparam int WAKE_LAST = srpd_pkg::WAKE_MAX_CYC - 1;

  // The force-sleep bit resets to its idle level, high, so that leaving
  // reset is not mistaken for a manual sleep request.
  localparam logic [SW-1:0] SYNC_RST = {1'b1, {(SW - 1){1'b0}}};

  // Synchronisers and edge detection.
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  logic [SW-1:0] sync3_r;
  logic [1:0] prime_r;
  logic armed;
  logic [NTX-1:0] tx_s;
  logic [NRX-1:0] rxl_s;
  logic [NRX-1:0] rxv_s;
  logic fa_s;
  logic fs_s;
  logic any_edge;
  logic any_valid;

  // Timebase and idle timer.
  logic [DW-1:0] div_r;
  logic us_tick;
  logic [IW-1:0] idle_r;
  logic idle_done;
  logic expired_r;

  // Power state and transmitter enable.
  logic pwr_on;
  logic pump_en_r;
  logic [CW-1:0] settle_r;
  logic tx_ready_r;
  logic [NTX-1:0] tx_oe_n_r;
  logic [NTX-1:0] tx_out_r;
  logic [NRX-1:0] rx_out_r;
  logic [CW-1:0] wake_cnt_r;

  // Line validity flag.
  logic [CW-1:0] inv_r;
  logic [CW-1:0] val_r;
  logic inv_n_r;

  // Register read path.
  logic [31:0] hrdata_r;
  srpd_pkg::srpd_status_s status;

  // Read decode of the two registers; any other address reads as zero.
  function automatic logic [31:0] read_word(input logic [31:0] addr,
                                            input srpd_pkg::srpd_status_s st,
                                            input logic fa,
                                            input logic fs);
    logic [31:0] rd_word;
    rd_word = srpd_pkg::RDATA_RST;
    case (addr)
      srpd_pkg::CTRL_OFS: rd_word = {30'h0, fa, fs};
      srpd_pkg::STATUS_OFS: rd_word = {26'h0, st};
      default: rd_word = srpd_pkg::RDATA_RST;
    endcase
    return rd_word;
  endfunction

  // Every pin passes two flip-flops; the third stage only feeds edge detection.
  always_ff @(posedge core_clk or posedge sys_rst) begin // [RULE21]
    if (sys_rst) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
      sync3_r <= SYNC_RST;
    end else begin
      sync1_r <= {force_sleep_n_in, force_active_in, rx_valid_in, rx_level_in, tx_data_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Edges are ignored until the chain holds real pin values, so that the
  // reset contents do not fake a wake-up.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prime_r <= 2'h0;
    end else if (prime_r != 2'h3) begin
      prime_r <= prime_r + 2'h1;
    end
  end

  assign armed = (prime_r == 2'h3);
  assign tx_s = sync2_r[NTX-1:0];
  assign rxl_s = sync2_r[LW-1:NTX];
  assign rxv_s = sync2_r[LW+NRX-1:LW];
  assign fa_s = sync2_r[SW-2];
  assign fs_s = sync2_r[SW-1];
  assign any_valid = |rxv_s;

  // A change of level in either direction on any data input is activity.
  assign any_edge = armed && (|(sync2_r[LW-1:0] ^ sync3_r[LW-1:0])); // [RULE19]

  // One-cycle pulse every microsecond.
  always_ff @(posedge core_clk or posedge sys_rst) begin // [RULE21]
    if (sys_rst) begin
      div_r <= '0;
    end else if (div_r == DW'(TICK_LAST)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DW'(1);
    end
  end

  assign us_tick = (div_r == DW'(TICK_LAST));

  // The idle timer only runs while automatic sleep is allowed and the device
  // is awake; a coarse microsecond tick keeps the counter narrow.
  assign idle_done = us_tick && !expired_r && fs_s && !fa_s && (idle_r == IW'(IDLE_LAST)); // [RULE5]

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idle_r <= '0;
    end else if (!fs_s || fa_s || any_edge || expired_r) begin // [RULE4] [RULE6]
      idle_r <= '0;
    end else if (idle_done) begin
      idle_r <= '0;
    end else if (us_tick) begin
      idle_r <= idle_r + IW'(1);
    end
  end

  // Manual sleep sets the expired state and beats any wake source. An edge
  // in the very cycle of expiry breaks the quiet interval, so it wins there.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      expired_r <= 1'b0;
    end else if (!fs_s) begin // [RULE2] [RULE7]
      expired_r <= 1'b1;
    end else if (fa_s || any_edge) begin // [RULE6] [RULE8] [RULE9]
      expired_r <= 1'b0;
    end else if (idle_done) begin // [RULE5]
      expired_r <= 1'b1;
    end
  end

  // Tied force inputs give plain shutdown: high means on, low means off.
  // The validity flag is deliberately not an input to this term.
  assign pwr_on = fs_s && (fa_s || !expired_r); // [RULE3] [RULE12] [RULE16]

  always_ff @(posedge core_clk or posedge sys_rst) begin // [RULE1]
    if (sys_rst) begin
      pump_en_r <= 1'b0;
    end else begin
      pump_en_r <= pwr_on;
    end
  end

  // Transmitters wait for the pump to settle; they are released well inside
  // the wake-up budget and tristated in the same cycle as the pump stops.
  always_ff @(posedge core_clk or posedge sys_rst) begin // [RULE1] [RULE10]
    if (sys_rst) begin
      settle_r <= '0;
      tx_ready_r <= 1'b0;
      tx_oe_n_r <= {NTX{1'b1}};
    end else if (!pwr_on) begin
      settle_r <= '0;
      tx_ready_r <= 1'b0;
      tx_oe_n_r <= {NTX{1'b1}};
    end else if (settle_r == CW'(SETTLE_LAST)) begin
      tx_ready_r <= 1'b1;
      tx_oe_n_r <= {NTX{1'b0}};
    end else begin
      settle_r <= settle_r + CW'(1);
    end
  end

  // Cycles since the pump came on without the transmitters being ready.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_cnt_r <= '0;
    end else if (!pump_en_r || tx_ready_r) begin
      wake_cnt_r <= '0;
    end else if (wake_cnt_r != CW'(WAKE_LAST)) begin
      wake_cnt_r <= wake_cnt_r + CW'(1);
    end
  end

  // Both driver kinds invert; receivers keep driving in every power state.
  always_ff @(posedge core_clk or posedge sys_rst) begin // [RULE18]
    if (sys_rst) begin
      tx_out_r <= {NTX{1'b1}};
      rx_out_r <= {NRX{1'b1}};
    end else begin
      tx_out_r <= ~tx_s;
      rx_out_r <= ~rxl_s;
    end
  end

  // Validity timers run in every mode, independent of the power state.
  always_ff @(posedge core_clk or posedge sys_rst) begin // [RULE15]
    if (sys_rst) begin
      inv_r <= '0;
    end else if (any_valid) begin
      inv_r <= '0;
    end else if (inv_r != CW'(INV_LAST)) begin
      inv_r <= inv_r + CW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      val_r <= '0;
    end else if (!any_valid) begin
      val_r <= '0;
    end else if (val_r != CW'(VAL_LAST)) begin
      val_r <= val_r + CW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      inv_n_r <= 1'b0;
    end else if (any_valid && (val_r == CW'(VAL_LAST))) begin // [RULE14]
      inv_n_r <= 1'b1;
    end else if (!any_valid && (inv_r == CW'(INV_LAST))) begin // [RULE13]
      inv_n_r <= 1'b0;
    end
  end

  // Status word as software sees it.
  always_comb begin
    status = '0;
    status.force_sleep_n = fs_s;
    status.force_active = fa_s;
    status.line_invalid_n = inv_n_r;
    status.expired = expired_r;
    status.tx_ready = tx_ready_r;
    status.powered = pump_en_r;
  end

  // Zero-wait-state slave: read data is loaded at the address phase and
  // stands through the data phase. Writes are accepted and ignored.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_r <= srpd_pkg::RDATA_RST;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      hrdata_r <= read_word(haddr, status, fa_s, fs_s);
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = srpd_pkg::HRESP_OKAY[0];
  assign pump_en = pump_en_r;
  assign tx_ready = tx_ready_r;
  assign tx_line_oe_n = tx_oe_n_r;
  assign tx_line_out = tx_out_r;
  assign rx_data_out = rx_out_r;
  assign line_invalid_n = inv_n_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Asleep with automatic sleep allowed and nothing happening.
  sequence s_quiet_asleep;
    !fa_s && fs_s && expired_r && !any_edge;
  endsequence

  // A wake source while manual sleep is not requested.
  sequence s_wake_event;
    fs_s && (fa_s || any_edge);
  endsequence

  // The idle interval ends and no wake source follows in the next cycle.
  sequence s_idle_expiry;
    (idle_done && !any_edge) ##1 (!fa_s && !any_edge);
  endsequence

  a_sleep_holds: assert property (s_quiet_asleep |=> expired_r) // [RULE7] [RULE8]
    else $error("sleep left without a wake event");
  a_wake_clears: assert property (s_wake_event |=> !expired_r) // [RULE6] [RULE9]
    else $error("wake event did not clear the idle state");
  a_auto_sleep: assert property (s_idle_expiry |=> !pump_en_r) // [RULE5]
    else $error("pump still on after the idle interval");
  a_force_sleep: assert property (!fs_s |=> !pump_en_r) // [RULE2]
    else $error("pump on during manual sleep");
  a_forced_on: assert property ((fa_s && fs_s) |=> pump_en_r) // [RULE3]
    else $error("pump off with both force inputs high");
  a_auto_gate: assert property ((fa_s || !fs_s) |=> (idle_r == '0)) // [RULE4]
    else $error("idle timer ran while automatic sleep is off");
  a_tx_tristate: assert property (!pump_en_r |-> (tx_line_oe_n == {NTX{1'b1}})) // [RULE1]
    else $error("transmitter driven with the pump off");
  a_wake_in_time: assert property (wake_cnt_r < CW'(WAKE_LAST)) // [RULE10]
    else $error("transmitters not ready in time after wake");
  a_flag_rise: assert property ($rose(line_invalid_n) |-> $past(any_valid)) // [RULE14]
    else $error("flag rose without a valid level");
  a_flag_fall: assert property ($fell(line_invalid_n) |-> $past(!any_valid)) // [RULE13]
    else $error("flag fell while a level was valid");
  a_rx_driven: assert property (rx_data_out == ~$past(rxl_s)) // [RULE18]
    else $error("receiver output does not follow its input");
endmodule // srpd_ctrl

// ### srpd_pkg.sv
// Notes on behaviour
// RULE1: Powerdown stops charge pump and tristates transmitters.
// RULE2: Force-sleep low always means manual powerdown.
// RULE3: Both force inputs high keeps device active.
// RULE4: Auto sleep only with active low, sleep high.
// RULE5: Auto sleep after idle interval without edges.
// RULE6: Any input edge wakes and restarts interval.
// RULE7: Idle timer stays expired after any powerdown.
// RULE8: Manual wake needs both forces high or edge.
// RULE9: Force-active wakes; full interval after it falls.
// RULE10: Transmitters ready within 100 us of wake.
// RULE11: Host holds force-active high for manual only.
// RULE12: Tied force inputs act as plain shutdown.
// RULE13: Flag low after 30 us all-invalid receivers.
// RULE14: Flag high 1 us after any valid level.
// RULE15: Invalid flag computed in every mode.
// RULE16: Invalid flag never changes power state internally.
// RULE17: Flag wired to forces follows receiver validity.
// RULE18: Receiver outputs always driven, never tristated.
// RULE19: Edge is threshold crossing in either direction.
// RULE20: Idle delay 30 s, within 15 to 60 s.
// RULE21: Inputs synchronised; timers from divided timebase; only the idle timer uses it, the others count core_clk.
package srpd_pkg;
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  localparam int IDLE_SLEEP_S = 30;
  localparam int IDLE_SLEEP_TICKS = IDLE_SLEEP_S * 1000000 / TICK_US;
  localparam int IDLE_W = 26;
  localparam int INVALID_US = 30;
  localparam int INVALID_CYC = INVALID_US * CLK_MHZ;
  localparam int VALID_US = 1;
  localparam int VALID_CYC = VALID_US * CLK_MHZ;
  localparam int WAKE_MAX_US = 100;
  localparam int WAKE_MAX_CYC = WAKE_MAX_US * CLK_MHZ;
  localparam int PUMP_SETTLE_US = 20;
  localparam int PUMP_SETTLE_CYC = PUMP_SETTLE_US * CLK_MHZ;
  localparam int CNT_W = 14;
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef struct packed {
    logic force_sleep_n;
    logic force_active;
    logic line_invalid_n;
    logic expired;
    logic tx_ready;
    logic powered;
  } srpd_status_s;
endpackage

// ### srpd_host.sv
`timescale 1ns/100ps
module srpd_host (
  input wire logic core_clk,
  input wire logic [1:0] mode,
  output logic [1:0] frc
);
  always_ff @(posedge core_clk) frc <= mode;
endmodule // srpd_host

// ### srpd_ctrl_bench.sv
`timescale 1ns/100ps
module srpd_ctrl_bench;
  logic core_clk = 0, sys_rst = 1, ho, hresp, pump, inv_n, rdy;
  logic [1:0] htrans = 0, mode = 1, frc;
  logic [2:0] tx = 0, rx = 0, rv = 0, oe, txo, rxo;
  logic [31:0] haddr = 0, rd;
  integer seed = 32'hD1AF, bad_count = 0, cmp_count = 0;
  srpd_host i_srpd_host (.core_clk, .mode, .frc);
  srpd_ctrl #(.IDLE_TICKS(100)) i_srpd_ctrl (.core_clk, .sys_rst, .hsel(1'b1), .haddr, .htrans,
    .hwrite(1'b0), .hsize(3'h2), .hwdata(32'h0), .hready(ho), .hrdata(rd), .hreadyout(ho), .hresp,
    .force_active_in(frc[1]), .force_sleep_n_in(frc[0]), .tx_data_in(tx), .tx_line_out(txo),
    .tx_line_oe_n(oe), .rx_level_in(rx), .rx_valid_in(rv), .rx_data_out(rxo), .pump_en(pump),
    .tx_ready(rdy), .line_invalid_n(inv_n));
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: %h not %h", $time, g, e);
    end
  endtask
  // Single read: address phase until ready, then data phase until ready.
  task automatic read_chk(input logic [31:0] a, e);
    htrans <= 2'h2;
    haddr <= a;
    do @(posedge core_clk); while (ho !== 1'b1);
    htrans <= 2'h0;
    do @(posedge core_clk); while (ho !== 1'b1);
    chk(rd, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d, bad %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Random edges every few microseconds keep the idle timer far from expiry.
  task automatic step(input logic [1:0] m, input int act, us, input logic p);
    mode <= m;
    repeat (us * 100) @(posedge core_clk) if (act != 0 && $random(seed) % 300 == 0) tx <= ~tx;
    #1;
    chk({pump, oe, rdy}, {p, {3{~p}}, p});
    chk(rxo, 3'(~rx));
    if (act == 0) chk(txo, 3'(~tx));
    $display("step %h done", m);
  endtask
  initial forever #5 core_clk = ~core_clk;
  initial begin
    #700000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 0;
    rv <= 3'h7;
    read_chk(32'h0000_0040, 32'h0000_0000);
    step(2'h1, 1, 120, 1);
    step(2'h1, 0, 120, 0);
    rx <= 3'h5;
    step(2'h1, 0, 90, 1);
    step(2'h0, 1, 10, 0);
    step(2'h1, 0, 10, 0);
    step(2'h3, 0, 120, 1);
    read_chk(32'h0000_0004, 32'h0000_003B);
    step(2'h1, 0, 90, 1);
    rv <= 3'h0;
    step(2'h0, 0, 40, 0);
    chk({3'h0, inv_n}, 4'h0);
    rv <= 3'h1 << ($unsigned($random(seed)) % 3);
    step(2'h0, 0, 2, 0);
    chk({3'h0, inv_n}, 4'h1);
    tally_and_finish;
  end
endmodule // srpd_ctrl_bench
